// >>> pkg/two_wire_defines.svh
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH
`define REG_CONTROL 2'h0
`define REG_STATUS 2'h1
`define REG_DATA 2'h2
`define REG_OWN_ADDR 2'h3
`define CTL_JOB_DONE 7
`define CTL_ACK_EN 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_WCOL 3
`define CTL_IF_EN 2
`define CTL_IRQ_EN 0
`define SC_START 8'h08
`define SC_RSTART 8'h10
`define SC_MT_ADDR_ACK 8'h18
`define SC_MT_ADDR_NACK 8'h20
`define SC_MT_DATA_ACK 8'h28
`define SC_MT_DATA_NACK 8'h30
`define SC_ARB_LOST 8'h38
`define SC_MR_ADDR_ACK 8'h40
`define SC_MR_ADDR_NACK 8'h48
`define SC_MR_DATA_ACK 8'h50
`define SC_MR_DATA_NACK 8'h58
`define SC_SR_ADDR 8'h60
`define SC_SR_ADDR_LOST 8'h68
`define SC_SR_GC 8'h70
`define SC_SR_GC_LOST 8'h78
`define SC_SR_DATA_ACK 8'h80
`define SC_SR_DATA_NACK 8'h88
`define SC_SR_GC_DATA_ACK 8'h90
`define SC_SR_GC_DATA_NACK 8'h98
`define SC_NO_INFO 8'hf8
`define SC_PRESCALER_MASK 8'hf8
`define GENERAL_CALL 7'h00
`define CLK_PERIOD_NS 10
`define QUARTER_NS 2500
`define QUARTER_CYCLES ((`QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH 16
`define FAR_ADDR 7'h2a
`endif

// >>> pkg/two_wire_pkg.sv
package two_wire_pkg;
  typedef enum logic [3:0] {
    IDLE = 4'h0, M_START = 4'h1, M_BIT = 4'h2, M_STOP = 4'h3,
    M_HOLD = 4'h4, S_BIT = 4'h5, S_ACK = 4'h6, S_HOLD = 4'h7
  } dev_state_t;
  typedef enum logic [2:0] {
    F_IDLE = 3'h0, F_ADDR = 3'h1, F_ADDR_ACK = 3'h2, F_LOAD = 3'h3, F_SEND = 3'h4, F_MACK = 3'h5
  } far_state_t;
  typedef struct packed {
    dev_state_t state;
    logic [7:0] ctrl;
    logic [7:0] status;
    logic [7:0] data;
    logic [7:0] own;
    logic [7:0] rdata;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic [1:0] quarter;
    logic [7:0] timer;
    logic rxMode;
    logic isAddr;
    logic dirRead;
    logic ackBit;
    logic lost;
    logic gc;
    logic owner;
    logic busy;
    logic sclOe;
    logic sdaOe;
    logic wake;
    logic irq;
  } dev_regs_t;
  typedef struct packed {
    far_state_t state;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic sclOe;
    logic sdaOe;
    logic nacked;
  } far_regs_t;
endpackage

// >>> pkg/two_wire_if.sv
`timescale 1ns/10ps
interface two_wire_if;
  logic devSclOut;
  logic devSclOe;
  logic devSdaOut;
  logic devSdaOe;
  logic farSclOut;
  logic farSclOe;
  logic farSdaOut;
  logic farSdaOe;
  logic scl;
  logic sda;
  // open-drain wired-and, released line pulled high
  assign scl = ~((devSclOe & ~devSclOut) | (farSclOe & ~farSclOut));
  assign sda = ~((devSdaOe & ~devSdaOut) | (farSdaOe & ~farSdaOut));
  modport device (input scl, input sda, output devSclOut, output devSclOe, output devSdaOut, output devSdaOe);
  modport far (input scl, input sda, output farSclOut, output farSclOe, output farSdaOut, output farSdaOe);
endinterface

// >>> hw/stream_fifo.sv
`timescale 1ns/10ps
`include "two_wire_defines.svh"
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("stream_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic next_inReady, next_outValid, push, pop;

  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem[rdPtr];

  always_comb begin
    next_wrPtr = wrPtr + AW'(push);
    next_rdPtr = rdPtr + AW'(pop);
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_inReady = next_count != (AW+1)'(DEPTH);
    next_outValid = next_count != '0;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      inReady <= next_inReady;
      outValid <= next_outValid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule

// >>> hw/two_wire_far_end.sv
`timescale 1ns/10ps
`include "two_wire_defines.svh"
module two_wire_far_end #(
  parameter logic [6:0] OWN_ADDR = `FAR_ADDR
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic masterNacked,
  two_wire_if.far bus
);
  import two_wire_pkg::*;
  far_regs_t r, n;
  logic [2:0] sclSync, sdaSync;
  logic sclF, sdaF, sclPrev, sdaPrev, sclRise, sclFall, startDet, stopDet;
  logic [7:0] fifoData;
  logic fifoValid, popByte;

  stream_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) txFifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .inData(txData),
    .inValid(txValid),
    .inReady(txReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(popByte)
  );

  assign sclRise = sclF & ~sclPrev;
  assign sclFall = ~sclF & sclPrev;
  assign startDet = sclF & sclPrev & sdaPrev & ~sdaF;
  assign stopDet = sclF & sclPrev & ~sdaPrev & sdaF;
  assign bus.farSclOut = 1'b0;
  assign bus.farSdaOut = 1'b0;
  assign bus.farSclOe = r.sclOe;
  assign bus.farSdaOe = r.sdaOe;
  assign masterNacked = r.nacked;

  ////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      sclF <= 1'b1;
      sdaF <= 1'b1;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[1:0], bus.scl};
      sdaSync <= {sdaSync[1:0], bus.sda};
      if (sclSync[1] == sclSync[2]) begin
        sclF <= sclSync[2];
      end
      if (sdaSync[1] == sdaSync[2]) begin
        sdaF <= sdaSync[2];
      end
      sclPrev <= sclF;
      sdaPrev <= sdaF;
    end
  end

  ////////////////////////////////////////
  always_comb begin
    n = r;
    n.nacked = 1'b0;
    popByte = 1'b0;
    if (stopDet) begin
      n.state = F_IDLE;
      n.sclOe = 1'b0;
      n.sdaOe = 1'b0;
    end else if (startDet) begin
      n.state = F_ADDR;
      n.bitCnt = 4'h0;
      n.sclOe = 1'b0;
      n.sdaOe = 1'b0;
    end else begin
      case (r.state)
        F_ADDR: begin
          if (sclRise && r.bitCnt != 4'h8) begin
            n.shift = {r.shift[6:0], sdaF};
            n.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == 4'h8) begin
            n.sdaOe = (r.shift == {OWN_ADDR, 1'b1});
            n.state = (r.shift == {OWN_ADDR, 1'b1}) ? F_ADDR_ACK : F_IDLE;
          end
        end
        F_ADDR_ACK: begin
          if (sclFall) begin
            n.sdaOe = 1'b0;
            n.state = F_LOAD;
          end
        end
        F_LOAD: begin
          // empty fifo stretches the clock
          if (fifoValid) begin
            popByte = 1'b1;
            n.shift = fifoData;
            n.sdaOe = ~fifoData[7];
            n.bitCnt = 4'h0;
            n.state = F_SEND;
          end else begin
            n.sclOe = 1'b1;
          end
        end
        F_SEND: begin
          // data settles a cycle before a stretched clock is let go
          n.sclOe = 1'b0;
          if (sclFall && r.bitCnt == 4'h7) begin
            n.sdaOe = 1'b0;
            n.state = F_MACK;
          end else if (sclFall) begin
            n.shift = {r.shift[6:0], 1'b0};
            n.sdaOe = ~r.shift[6];
            n.bitCnt = r.bitCnt + 4'h1;
          end
        end
        F_MACK: begin
          if (sclRise && sdaF) begin
            n.nacked = 1'b1;
            n.state = F_IDLE;
          end else if (sclFall) begin
            n.state = F_LOAD;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// >>> hw/two_wire_device.sv
`timescale 1ns/10ps
`include "two_wire_defines.svh"
module two_wire_device #(
  parameter int QUARTER_CYC = `QUARTER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic clockStopped,
  output logic wakeUp,
  output logic irq,
  two_wire_if.device bus
);
  import two_wire_pkg::*;
  generate
    if (QUARTER_CYC < 2 || QUARTER_CYC > 256) begin : g_bad
      $error("two_wire_device: QUARTER_CYC must lie in 2..256");
    end
  endgenerate
  dev_regs_t r, n;
  logic [2:0] sclSync, sdaSync;
  logic sclF, sdaF, sclPrev, sdaPrev, sclRise, sclFall, startDet, stopDet;
  logic tick, step, ownHit, gcHit, lose;
  logic [7:0] reload;

  assign reload = 8'(QUARTER_CYC - 1);
  assign tick = (r.timer == 8'h00);
  assign sclRise = sclF & ~sclPrev;
  assign sclFall = ~sclF & sclPrev;
  assign startDet = sclF & sclPrev & sdaPrev & ~sdaF;
  assign stopDet = sclF & sclPrev & ~sdaPrev & sdaF;
  assign ownHit = (r.shift[7:1] == r.own[7:1]);
  assign gcHit = r.own[0] & (r.shift[7:1] == `GENERAL_CALL);
  assign regRdata = r.rdata;
  assign wakeUp = r.wake;
  assign irq = r.irq;
  assign bus.devSclOut = 1'b0;
  assign bus.devSdaOut = 1'b0;
  assign bus.devSclOe = r.sclOe;
  assign bus.devSdaOe = r.sdaOe;

  ////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      sclF <= 1'b1;
      sdaF <= 1'b1;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[1:0], bus.scl};
      sdaSync <= {sdaSync[1:0], bus.sda};
      if (sclSync[1] == sclSync[2]) begin
        sclF <= sclSync[2];
      end
      if (sdaSync[1] == sdaSync[2]) begin
        sdaF <= sdaSync[2];
      end
      sclPrev <= sclF;
      sdaPrev <= sdaF;
    end
  end

  ////////////////////////////////////////
  always_comb begin
    n = r;
    // quarter two waits for a stretched clock to rise
    step = tick & ~(r.quarter == 2'h2 & ~sclF);
    lose = ~r.sdaOe & ~sdaF & (r.rxMode == (r.bitCnt == 4'h8));
    n.timer = tick ? reload : r.timer - 8'h01;
    n.busy = startDet | (r.busy & ~stopDet);
    if (regWrite) begin
      if (regAddr == `REG_CONTROL) begin
        n.ctrl = {r.ctrl[7] & ~regWdata[7], regWdata[6:4], r.ctrl[3], regWdata[2], 1'b0, regWdata[0]};
      end else if (regAddr == `REG_DATA) begin
        n.data = r.ctrl[`CTL_JOB_DONE] ? regWdata : r.data;
        n.ctrl[`CTL_WCOL] = ~r.ctrl[`CTL_JOB_DONE];
      end else if (regAddr == `REG_OWN_ADDR) begin
        n.own = regWdata;
      end
    end
    case (r.state)
      IDLE: begin
        n.sclOe = 1'b0;
        n.sdaOe = 1'b0;
        n.quarter = 2'h0;
        if (r.ctrl[`CTL_IF_EN] & r.ctrl[`CTL_START] & ~r.ctrl[`CTL_JOB_DONE] & ~r.busy) begin
          n.state = M_START;
          n.timer = reload;
        end else if (startDet) begin
          n.state = S_BIT;
          n.isAddr = 1'b1;
          n.bitCnt = 4'h0;
          n.lost = 1'b0;
        end
      end
      M_START: begin
        if (step) begin
          n.quarter = r.quarter + 2'h1;
          case (r.quarter)
            2'h0: n.sdaOe = 1'b0;
            2'h1: n.sclOe = 1'b0;
            2'h2: n.sdaOe = 1'b1;
            default: begin
              n.sclOe = 1'b1;
              n.ctrl[`CTL_JOB_DONE] = 1'b1;
              n.status = r.owner ? `SC_RSTART : `SC_START;
              n.owner = 1'b1;
              n.state = M_HOLD;
            end
          endcase
        end
      end
      M_STOP: begin
        if (step) begin
          n.quarter = r.quarter + 2'h1;
          case (r.quarter)
            2'h0: n.sdaOe = 1'b1;
            2'h1: n.sclOe = 1'b0;
            2'h2: n.sdaOe = 1'b0;
            default: begin
              n.ctrl[`CTL_STOP] = 1'b0;
              n.owner = 1'b0;
              n.state = IDLE;
            end
          endcase
        end
      end
      M_BIT: begin
        if (step) begin
          n.quarter = r.quarter + 2'h1;
          case (r.quarter)
            2'h0: begin
              if (r.bitCnt == 4'h8 && r.rxMode) begin
                n.sdaOe = r.ctrl[`CTL_ACK_EN];
                n.ackBit = r.ctrl[`CTL_ACK_EN];
              end else begin
                n.sdaOe = (r.bitCnt != 4'h8) & ~r.rxMode & ~r.shift[7];
              end
            end
            2'h1: n.sclOe = 1'b0;
            2'h2: begin
              if (lose) begin
                n.owner = 1'b0;
                n.sclOe = 1'b0;
                n.lost = 1'b1;
                if (r.isAddr && r.bitCnt != 4'h8) begin
                  n.shift = {r.shift[6:0], sdaF};
                  n.bitCnt = r.bitCnt + 4'h1;
                  n.state = S_BIT;
                end else begin
                  n.ctrl[`CTL_JOB_DONE] = 1'b1;
                  n.status = `SC_ARB_LOST;
                  n.state = M_HOLD;
                end
              end else if (r.bitCnt == 4'h8) begin
                n.ackBit = r.rxMode ? r.ackBit : ~sdaF;
              end else begin
                n.shift = {r.shift[6:0], sdaF};
              end
            end
            default: begin
              n.sclOe = 1'b1;
              n.bitCnt = r.bitCnt + 4'h1;
              if (r.bitCnt == 4'h8) begin
                n.ctrl[`CTL_JOB_DONE] = 1'b1;
                n.state = M_HOLD;
                if (r.rxMode) begin
                  n.status = r.ackBit ? `SC_MR_DATA_ACK : `SC_MR_DATA_NACK;
                  n.data = clockStopped ? r.data : r.shift;
                end else if (r.isAddr && r.dirRead) begin
                  n.status = r.ackBit ? `SC_MR_ADDR_ACK : `SC_MR_ADDR_NACK;
                end else if (r.isAddr) begin
                  n.status = r.ackBit ? `SC_MT_ADDR_ACK : `SC_MT_ADDR_NACK;
                end else begin
                  n.status = r.ackBit ? `SC_MT_DATA_ACK : `SC_MT_DATA_NACK;
                end
              end
            end
          endcase
        end
      end
      M_HOLD: begin
        if (~r.ctrl[`CTL_JOB_DONE]) begin
          n.quarter = 2'h0;
          n.timer = reload;
          n.bitCnt = 4'h0;
          if (r.status == `SC_ARB_LOST) begin
            n.state = IDLE;
          end else if (r.ctrl[`CTL_STOP]) begin
            n.state = M_STOP;
          end else if (r.ctrl[`CTL_START]) begin
            n.state = M_START;
          end else if (r.status == `SC_START || r.status == `SC_RSTART) begin
            n.state = M_BIT;
            n.shift = r.data;
            n.rxMode = 1'b0;
            n.isAddr = 1'b1;
            n.dirRead = r.data[0];
          end else if (r.status == `SC_MT_ADDR_ACK || r.status == `SC_MT_DATA_ACK) begin
            n.state = M_BIT;
            n.shift = r.data;
            n.rxMode = 1'b0;
            n.isAddr = 1'b0;
          end else if (r.status == `SC_MR_ADDR_ACK || r.status == `SC_MR_DATA_ACK) begin
            n.state = M_BIT;
            n.rxMode = 1'b1;
            n.isAddr = 1'b0;
          end
        end
      end
      S_BIT: begin
        if (stopDet) begin
          n.state = IDLE;
        end else if (startDet) begin
          n.isAddr = 1'b1;
          n.bitCnt = 4'h0;
          n.lost = 1'b0;
        end else if (sclRise && r.bitCnt != 4'h8) begin
          n.shift = {r.shift[6:0], sdaF};
          n.bitCnt = r.bitCnt + 4'h1;
        end else if (sclFall && r.bitCnt == 4'h8) begin
          if (!r.isAddr) begin
            n.ackBit = r.ctrl[`CTL_ACK_EN];
            n.sdaOe = r.ctrl[`CTL_ACK_EN];
            n.data = clockStopped ? r.data : r.shift;
            n.state = S_ACK;
          end else if (r.ctrl[`CTL_ACK_EN] & ~r.shift[0] & (ownHit | gcHit)) begin
            n.sdaOe = 1'b1;
            n.gc = gcHit & ~ownHit;
            n.wake = clockStopped;
            n.state = S_ACK;
          end else if (r.lost) begin
            n.ctrl[`CTL_JOB_DONE] = 1'b1;
            n.status = `SC_ARB_LOST;
            n.state = M_HOLD;
          end else begin
            n.state = IDLE;
          end
        end
      end
      S_ACK: begin
        if (sclFall) begin
          n.sdaOe = 1'b0;
          n.sclOe = 1'b1;
          n.ctrl[`CTL_JOB_DONE] = 1'b1;
          n.state = S_HOLD;
          if (r.isAddr) begin
            n.status = r.gc ? (r.lost ? `SC_SR_GC_LOST : `SC_SR_GC)
                            : (r.lost ? `SC_SR_ADDR_LOST : `SC_SR_ADDR);
          end else begin
            n.status = r.gc ? (r.ackBit ? `SC_SR_GC_DATA_ACK : `SC_SR_GC_DATA_NACK)
                            : (r.ackBit ? `SC_SR_DATA_ACK : `SC_SR_DATA_NACK);
          end
        end
      end
      S_HOLD: begin
        if (~r.ctrl[`CTL_JOB_DONE]) begin
          n.sclOe = 1'b0;
          n.lost = 1'b0;
          n.isAddr = 1'b0;
          n.bitCnt = 4'h0;
          n.state = (r.status == `SC_SR_DATA_NACK || r.status == `SC_SR_GC_DATA_NACK) ? IDLE : S_BIT;
        end
      end
      default: n.state = IDLE;
    endcase
    if (~r.ctrl[`CTL_IF_EN]) begin
      n.state = IDLE;
      n.sclOe = 1'b0;
      n.sdaOe = 1'b0;
      n.owner = 1'b0;
    end
    n.wake = n.wake & clockStopped;
    n.irq = n.ctrl[`CTL_JOB_DONE] & n.ctrl[`CTL_IRQ_EN];
    if (regAddr == `REG_CONTROL) begin
      n.rdata = r.ctrl;
    end else if (regAddr == `REG_STATUS) begin
      n.rdata = r.status & `SC_PRESCALER_MASK;
    end else if (regAddr == `REG_DATA) begin
      n.rdata = r.data;
    end else begin
      n.rdata = r.own;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.status <= `SC_NO_INFO;
    end else begin
      r <= n;
    end
  end
endmodule

// >>> verification/two_wire_props.sv
`timescale 1ns/10ps
module two_wire_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic devSclOut,
  input wire logic devSclOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic farSclOut,
  input wire logic farSclOe,
  input wire logic farSdaOut,
  input wire logic farSdaOe,
  input wire logic scl,
  input wire logic sda
);
  localparam int START_GAP = 40;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  sequence startCond;
    scl && $fell(sda);
  endsequence
  sequence stopCond;
    scl && $rose(sda);
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  dev_open_drain_a: assert property (!devSclOut && !devSdaOut)
    else $error("device drives a line high");
  far_open_drain_a: assert property (!farSclOut && !farSdaOut)
    else $error("far end drives a line high");
  start_by_master_a: assert property (startCond |-> devSdaOe)
    else $error("start not made by device");
  start_then_clock_a: assert property (startCond |-> ##[1:START_GAP] devSclOe)
    else $error("no clock low after start");
  stop_by_master_a: assert property (stopCond |-> $past(devSdaOe))
    else $error("stop not made by device");
  stop_releases_a: assert property (stopCond |=> (!devSclOe && !devSdaOe)[*4])
    else $error("bus not released after stop");
  clock_low_hold_a: assert property ($rose(devSclOe) |=> devSclOe[*3])
    else $error("clock low phase too short");
  far_data_change_a: assert property ($changed(farSdaOe) |-> !scl)
    else $error("far end changed data while clock high");
  far_stretch_low_a: assert property ($rose(farSclOe) |-> !$past(scl))
    else $error("far end pulled clock low while high");
endmodule

// >>> verification/two_wire_master_rx_slave_rx_tb.sv
`timescale 1ns/10ps
`include "two_wire_defines.svh"
module two_wire_master_rx_slave_rx_tb;
  import two_wire_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic regWrite = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic irq;
  logic clockStopped = 1'b0;
  logic wakeUp;
  logic [7:0] txData = 8'h00;
  logic txValid = 1'b0;
  logic txReady;
  logic masterNacked;
  int miscompares = 0;
  int cmp_count = 0;
  int nackCount = 0;
  int i;
  logic [7:0] v;
  two_wire_if busIf ();
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (masterNacked === 1'b1) nackCount <= nackCount + 1;
  //////////////////////////////////////////////////////////////////////////////
  two_wire_device #(.QUARTER_CYC(4)) two_wire_device_inst (
    .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .clockStopped(clockStopped), .wakeUp(wakeUp),
    .irq(irq), .bus(busIf)
  );
  two_wire_far_end two_wire_far_end_inst (
    .sys_clk(sys_clk), .reset(reset), .txData(txData), .txValid(txValid),
    .txReady(txReady), .masterNacked(masterNacked), .bus(busIf)
  );
  two_wire_props two_wire_props_inst (
    .sys_clk(sys_clk), .reset(reset), .devSclOut(busIf.devSclOut), .devSclOe(busIf.devSclOe),
    .devSdaOut(busIf.devSdaOut), .devSdaOe(busIf.devSdaOe), .farSclOut(busIf.farSclOut),
    .farSclOe(busIf.farSclOe), .farSdaOut(busIf.farSdaOut), .farSdaOe(busIf.farSdaOe),
    .scl(busIf.scl), .sda(busIf.sda)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic regWr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(posedge sys_clk);
    #1;
    regWrite = 1'b0;
  endtask
  task automatic regRd(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    regAddr = a;
    @(posedge sys_clk);
    #1;
    d = regRdata;
  endtask
  // poll the flag with a bound, then compare the status code
  task automatic waitFlag(input logic [7:0] s);
    int n;
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1 && n < 4000) begin
      regRd(`REG_CONTROL, v);
      n++;
    end
    regRd(`REG_STATUS, v);
    check("status", v, s);
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] s);
    regWr(`REG_CONTROL, c);
    waitFlag(s);
  endtask
  task automatic sendAddr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] s);
    regWr(`REG_DATA, a);
    step(c, s);
  endtask
  task automatic stopWait;
    int n;
    n = 0;
    v = 8'h10;
    while (v[4] !== 1'b0 && n < 4000) begin
      regRd(`REG_CONTROL, v);
      n++;
    end
    check("stop bit", v & 8'h10, 8'h00);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    for (i = 0; i < 4; i++) begin
      regRd(i[1:0], v);
      check("reset value", v, (i == 1) ? `SC_NO_INFO : 8'h00);
    end
    // data write without flag is refused
    regWr(`REG_DATA, 8'h77);
    regRd(`REG_CONTROL, v);
    check("collision", v, 8'h08);
    regRd(`REG_DATA, v);
    check("data kept", v, 8'h00);
    regWr(`REG_OWN_ADDR, 8'h63);
    regRd(`REG_OWN_ADDR, v);
    check("own address", v, 8'h63);
    regWr(`REG_CONTROL, 8'h44);
    regRd(`REG_CONTROL, v);
    check("slave ready", v, 8'h4c);
    // fill the far fifo until it refuses
    txValid = 1'b1;
    for (i = 0; i < 16; i++) begin
      txData = 8'h10 + i[7:0];
      @(posedge sys_clk);
      #1;
    end
    txData = 8'hee;
    @(posedge sys_clk);
    #1;
    check("fifo full", {7'h0, txReady}, 8'h00);
    txValid = 1'b0;
    // master read of sixteen bytes, last one not acknowledged
    step(8'ha4, `SC_START);
    check("irq masked", {7'h0, irq}, 8'h00);
    sendAddr({`FAR_ADDR, 1'b1}, 8'hc5, `SC_MR_ADDR_ACK);
    check("irq", {7'h0, irq}, 8'h01);
    regRd(`REG_CONTROL, v);
    check("collision cleared", v & 8'h08, 8'h00);
    for (i = 0; i < 16; i++) begin
      step((i == 15) ? 8'h85 : 8'hc5, (i == 15) ? `SC_MR_DATA_NACK : `SC_MR_DATA_ACK);
      regRd(`REG_DATA, v);
      check("rx byte", v, 8'h10 + i[7:0]);
    end
    regWr(`REG_CONTROL, 8'h95);
    stopWait;
    check("nack count", nackCount[7:0], 8'h01);
    check("bus free", {6'h0, busIf.scl, busIf.sda}, 8'h03);
    // unanswered address, repeated start, write address, stop then start
    step(8'ha5, `SC_START);
    sendAddr(8'h63, 8'h85, `SC_MR_ADDR_NACK);
    step(8'ha5, `SC_RSTART);
    sendAddr(8'h62, 8'h85, `SC_MT_ADDR_NACK);
    step(8'hb5, `SC_START);
    regRd(`REG_CONTROL, v);
    check("stop cleared", v & 8'h10, 8'h00);
    sendAddr(8'h63, 8'h85, `SC_MR_ADDR_NACK);
    regWr(`REG_CONTROL, 8'h95);
    stopWait;
    // empty far fifo stretches the clock, sleep keeps the data register
    clockStopped = 1'b1;
    step(8'ha5, `SC_START);
    sendAddr({`FAR_ADDR, 1'b1}, 8'h85, `SC_MR_ADDR_ACK);
    regWr(`REG_CONTROL, 8'h85);
    repeat (40) @(posedge sys_clk);
    #1;
    check("stretch", {6'h0, busIf.scl, busIf.farSclOe}, 8'h01);
    txData = 8'h3c;
    txValid = 1'b1;
    @(posedge sys_clk);
    #1;
    txValid = 1'b0;
    waitFlag(`SC_MR_DATA_NACK);
    regRd(`REG_DATA, v);
    check("sleep data", v, {`FAR_ADDR, 1'b1});
    check("no wake", {7'h0, wakeUp}, 8'h00);
    regWr(`REG_CONTROL, 8'h95);
    stopWait;
    check("nack count", nackCount[7:0], 8'h02);
    clockStopped = 1'b0;
    stop_test;
  end
endmodule
